// ---- verilog/rvr_pkg.sv ----
`default_nettype none
package rvr_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] RVR_ADDR_VOLMIX = 8'h02;   // Volume and mixing control
    localparam logic [7:0] RVR_ADDR_VOL_A  = 8'h03;   // Channel A volume
    localparam logic [7:0] RVR_ADDR_VOL_B  = 8'h04;   // Channel B volume
    localparam logic [7:0] RVR_ADDR_MODE3  = 8'h06;   // Reset ramp mode control
    localparam logic [7:0] RVR_ADDR_ID     = 8'h07;   // Chip identification

    // ****************************************
    // Field positions and masks
    // ****************************************
    localparam int         RVR_SOFT_HI     = 6;       // Soft/zero field, upper bit
    localparam int         RVR_SOFT_LO     = 5;       // Soft/zero field, lower bit
    localparam int         RVR_RAMP_UP_BIT = 3;       // Ramp up after reset
    localparam int         RVR_RAMP_DN_BIT = 2;       // Ramp down before reset
    localparam int         RVR_MUTE_BIT    = 7;       // Channel mute
    localparam logic [7:0] RVR_MODE3_MASK  = 8'h1c;   // Writable bits of mode 3

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] RVR_VOLMIX_RST  = 8'h40;   // Soft ramp selected
    localparam logic [7:0] RVR_VOL_RST     = 8'h00;   // 0 dB, unmuted
    localparam logic [7:0] RVR_MODE3_RST   = 8'h00;   // Both ramp bits clear

    // ****************************************
    // Identification (values arbitrary)
    // ****************************************
    localparam logic [3:0] RVR_PART_ID     = 4'h5;    // Arbitrary part value
    localparam logic [3:0] RVR_REV_ID      = 4'h1;    // Arbitrary revision value

    // ****************************************
    // Attenuation and change modes
    // ****************************************
    localparam logic [6:0] RVR_ATTEN_MAX   = 7'h7f;   // 127 dB
    localparam logic [1:0] RVR_MODE_IMM    = 2'h0;    // Immediate
    localparam logic [1:0] RVR_MODE_ZC     = 2'h1;    // Zero cross only
    localparam logic [1:0] RVR_MODE_SOFT   = 2'h2;    // Soft ramp only
    localparam logic [1:0] RVR_MODE_BOTH   = 2'h3;    // Soft ramp and zero cross

    // Sequencer states
    typedef enum logic [1:0] {
        RVR_HOLD,
        RVR_RAMP_UP,
        RVR_RUN,
        RVR_RAMP_DOWN
    } rvr_state_t;
endpackage : rvr_pkg
`default_nettype wire

// ---- verilog/rvr_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module rvr_top
    import rvr_pkg::*;
(
    input  wire logic       clk,                 // Master clock
    input  wire logic       rstn,                // Synchronous reset
    input  wire logic [7:0] ctl_addr,            // Control port address
    input  wire logic [7:0] ctl_wdata,           // Control port write data
    input  wire logic       ctl_wr,              // Write strobe
    input  wire logic       ctl_rd,              // Read strobe
    output var  logic [7:0] ctl_rdata,           // Read data
    input  wire logic       reset_pin_n,         // Reset pin level
    input  wire logic       internal_reset_req,  // Internally raised reset
    input  wire logic       sample_strobe,       // One pulse per sample frame
    input  wire logic       zero_cross_a,        // Channel A zero crossing
    input  wire logic       zero_cross_b,        // Channel B zero crossing
    output var  logic [6:0] atten_a,             // Applied attenuation A
    output var  logic [6:0] atten_b,             // Applied attenuation B
    output var  logic       reset_go,            // Reset action may proceed
    output var  logic       ramp_busy            // Ramp around reset running
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        rvr_state_t       st;      // Sequencer state
        logic [1:0][6:0]  atten;   // Applied attenuation per channel
        logic [1:0][7:0]  vol;     // Channel volume registers
        logic [7:0]       volmix;  // Volume and mixing control
        logic [7:0]       mode3;   // Reset ramp mode control
        logic [7:0]       rdata;   // Read data
        logic             go;      // Reset action allowed
        logic             busy;    // Ramp in progress
    } rvr_regs_t;

    rvr_regs_t       q;            // Registered state
    rvr_regs_t       next_q;       // Next state
    logic            req;          // Any reset request
    logic [1:0]      zc;           // Zero crossings per channel
    logic [1:0]      mode;         // Soft/zero mode
    logic [1:0][6:0] tgt;          // Programmed targets
    logic            at_tgt;       // Both channels at target
    logic            at_max;       // Both channels at max

    // Pin and internal requests merged alike
    assign req  = !reset_pin_n || internal_reset_req;
    assign zc   = {zero_cross_b, zero_cross_a};
    assign mode = q.volmix[RVR_SOFT_HI:RVR_SOFT_LO];

    // Targets; mute forces maximum attenuation
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            tgt[i] = q.vol[i][RVR_MUTE_BIT] ? RVR_ATTEN_MAX : q.vol[i][6:0];
        end
    end

    assign at_tgt = (q.atten[0] == tgt[0]) && (q.atten[1] == tgt[1]);
    assign at_max = (q.atten[0] == RVR_ATTEN_MAX) && (q.atten[1] == RVR_ATTEN_MAX);

    // ****************************************
    // Attenuation walker
    // ****************************************
    // One move toward the goal under the soft/zero mode
    function automatic logic [6:0] rvr_walk(input logic [6:0] cur,
                                            input logic [6:0] goal,
                                            input logic [1:0] md,
                                            input logic       stb,
                                            input logic       zx);
        logic [6:0] res;
        res = cur;
        unique case (md)
            RVR_MODE_IMM:  res = goal;
            RVR_MODE_ZC:   if (zx) res = goal;
            RVR_MODE_SOFT,
            RVR_MODE_BOTH: begin
                // One dB per sample, or per zero crossing
                if ((md == RVR_MODE_SOFT) ? stb : zx) begin
                    if (cur < goal) begin
                        res = cur + 7'h01;
                    end else if (cur > goal) begin
                        res = cur - 7'h01;
                    end
                end
            end
        endcase
        return res;
    endfunction : rvr_walk

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_q = q;
        // Register writes; identification ignores writes
        if (ctl_wr) begin
            unique case (ctl_addr)
                RVR_ADDR_VOLMIX: next_q.volmix = ctl_wdata;
                RVR_ADDR_VOL_A:  next_q.vol[0] = ctl_wdata;
                RVR_ADDR_VOL_B:  next_q.vol[1] = ctl_wdata;
                RVR_ADDR_MODE3:  next_q.mode3  = ctl_wdata & RVR_MODE3_MASK;
                default:         ;
            endcase
        end
        // Register reads, unmapped read as zero
        if (ctl_rd) begin
            unique case (ctl_addr)
                RVR_ADDR_VOLMIX: next_q.rdata = q.volmix;
                RVR_ADDR_VOL_A:  next_q.rdata = q.vol[0];
                RVR_ADDR_VOL_B:  next_q.rdata = q.vol[1];
                RVR_ADDR_MODE3:  next_q.rdata = q.mode3;
                RVR_ADDR_ID:     next_q.rdata = {RVR_PART_ID, RVR_REV_ID};
                default:         next_q.rdata = 8'h00;
            endcase
        end
        // Reset sequencer
        unique case (q.st)
            RVR_HOLD: begin
                // Held at max while reset stands
                next_q.atten = {RVR_ATTEN_MAX, RVR_ATTEN_MAX};
                if (!req) begin
                    if (q.mode3[RVR_RAMP_UP_BIT]) begin
                        next_q.st = RVR_RAMP_UP;
                    end else begin
                        next_q.atten = tgt;
                        next_q.st    = RVR_RUN;
                    end
                end
            end
            RVR_RAMP_UP, RVR_RUN: begin
                if (req) begin
                    if (q.mode3[RVR_RAMP_DN_BIT]) begin
                        next_q.st = RVR_RAMP_DOWN;
                    end else begin
                        next_q.atten = {RVR_ATTEN_MAX, RVR_ATTEN_MAX};
                        next_q.st    = RVR_HOLD;
                    end
                end else begin
                    // Walk toward programmed volume
                    for (int i = 0; i < 2; i++) begin
                        next_q.atten[i] = rvr_walk(q.atten[i], tgt[i], mode,
                                                   sample_strobe, zc[i]);
                    end
                    if (q.st == RVR_RAMP_UP && at_tgt) begin
                        next_q.st = RVR_RUN;
                    end
                end
            end
            RVR_RAMP_DOWN: begin
                // Reset action waits for max attenuation
                if (at_max) begin
                    next_q.st = RVR_HOLD;
                end else begin
                    for (int i = 0; i < 2; i++) begin
                        next_q.atten[i] = rvr_walk(q.atten[i], RVR_ATTEN_MAX, mode,
                                                   sample_strobe, zc[i]);
                    end
                end
            end
        endcase
        next_q.go   = (next_q.st == RVR_HOLD);
        next_q.busy = (next_q.st == RVR_RAMP_UP) || (next_q.st == RVR_RAMP_DOWN);
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            q.st     <= RVR_HOLD;
            q.atten  <= {RVR_ATTEN_MAX, RVR_ATTEN_MAX};
            q.vol    <= {RVR_VOL_RST, RVR_VOL_RST};
            q.volmix <= RVR_VOLMIX_RST;
            q.mode3  <= RVR_MODE3_RST;
            q.rdata  <= 8'h00;
            q.go     <= 1'b1;
            q.busy   <= 1'b0;
        end else begin
            q <= next_q;
        end
    end

    // Outputs straight from flops
    assign ctl_rdata = q.rdata;
    assign atten_a   = q.atten[0];
    assign atten_b   = q.atten[1];
    assign reset_go  = q.go;
    assign ramp_busy = q.busy;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // Identification read ignores earlier writes
    id_read_fixed_a: assert property (ctl_rd && ctl_addr == RVR_ADDR_ID |=>
        ctl_rdata == {RVR_PART_ID, RVR_REV_ID})
        else $error("identification read wrong");
    id_write_ignored_a: assert property (ctl_wr && ctl_addr == RVR_ADDR_ID |=>
        q.volmix == $past(q.volmix) && q.mode3 == $past(q.mode3))
        else $error("identification write disturbed registers");
    jump_up_a: assert property (q.st == RVR_HOLD && !req && !q.mode3[RVR_RAMP_UP_BIT]
        |=> q.st == RVR_RUN && atten_a == $past(tgt[0]) && atten_b == $past(tgt[1]))
        else $error("no jump to volume on release");
    ramp_up_enter_a: assert property (q.st == RVR_HOLD && !req
        && q.mode3[RVR_RAMP_UP_BIT] |=> q.st == RVR_RAMP_UP && ramp_busy && at_max)
        else $error("ramp up not started");
    soft_step_a: assert property (q.st == RVR_RAMP_UP && !req && mode == RVR_MODE_SOFT
        && sample_strobe && atten_a > tgt[0] |=> atten_a == $past(atten_a) - 7'h01)
        else $error("soft ramp step wrong");
    pin_internal_a: assert property (q.st == RVR_RUN && internal_reset_req
        && reset_pin_n |=> q.st != RVR_RUN)
        else $error("internal reset ignored");
    jump_down_a: assert property (q.st == RVR_RUN && req && !q.mode3[RVR_RAMP_DN_BIT]
        |=> reset_go && at_max)
        else $error("no jump to max on reset");
    ramp_down_a: assert property (q.st == RVR_RUN && req && q.mode3[RVR_RAMP_DN_BIT]
        |=> q.st == RVR_RAMP_DOWN && !reset_go ##1 ramp_busy || reset_go)
        else $error("ramp down not started");
    go_at_max_a: assert property ($rose(reset_go) |-> at_max)
        else $error("reset action before max attenuation");
    hold_max_a: assert property (q.st == RVR_HOLD |-> at_max)
        else $error("hold not at max attenuation");

    up_cov: cover property (q.st == RVR_RAMP_UP ##1 q.st == RVR_RUN);
    down_cov: cover property (q.st == RVR_RAMP_DOWN ##1 q.st == RVR_HOLD);
    zc_cov: cover property (q.st == RVR_RAMP_UP && mode == RVR_MODE_BOTH && zero_cross_a);
endmodule : rvr_top
`default_nettype wire

// ---- tb/rvr_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb;
    import rvr_pkg::*;
    // ****************************************
    // Signals and model state
    // ****************************************
    logic       clk, rstn, ctl_wr, ctl_rd, reset_pin_n, internal_reset_req;
    logic       sample_strobe, zero_cross_a, zero_cross_b, reset_go, ramp_busy;
    logic [7:0] ctl_addr, ctl_wdata, ctl_rdata;
    logic [6:0] atten_a, atten_b, pa, pb;
    logic [7:0] rg [8];                 // Register model
    int         mismatches, num_checks;

    rvr_top i_dut (.clk(clk), .rstn(rstn), .ctl_addr(ctl_addr), .ctl_wdata(ctl_wdata),
        .ctl_wr(ctl_wr), .ctl_rd(ctl_rd), .ctl_rdata(ctl_rdata), .reset_pin_n(reset_pin_n),
        .internal_reset_req(internal_reset_req), .sample_strobe(sample_strobe),
        .zero_cross_a(zero_cross_a), .zero_cross_b(zero_cross_b), .atten_a(atten_a),
        .atten_b(atten_b), .reset_go(reset_go), .ramp_busy(ramp_busy));

    // Clock, 5 ns period
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Random pacing of ramps
    always @(posedge clk) begin
        #1;
        sample_strobe = 1'($urandom);
        zero_cross_a  = ($urandom % 4) == 0;
        zero_cross_b  = ($urandom % 4) == 0;
    end

    // ****************************************
    // Helpers
    // ****************************************
    task automatic tick;
        @(posedge clk);
        #1;
    endtask : tick

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    function automatic logic [6:0] tgt(input int ch);
        return rg[3+ch][7] ? RVR_ATTEN_MAX : rg[3+ch][6:0];
    endfunction : tgt

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        ctl_addr  = a;
        ctl_wdata = d;
        ctl_wr    = 1'b1;
        tick();
        ctl_wr = 1'b0;
        if (a inside {8'h02, 8'h03, 8'h04}) rg[a[2:0]] = d;
        if (a == 8'h06) rg[6] = d & 8'h1c;
        tick();
    endtask : wr

    task automatic rd(input logic [7:0] a);
        logic [7:0] e;
        e = (a inside {8'h02, 8'h03, 8'h04, 8'h06}) ? rg[a[2:0]] : 8'h00;
        if (a == 8'h07) e = {RVR_PART_ID, RVR_REV_ID};
        ctl_addr = a;
        ctl_rd   = 1'b1;
        tick();
        ctl_rd = 1'b0;
        tick();
        chk(ctl_rdata, e);
    endtask : rd

    // One request and release around reset
    task automatic seq(input int kind, input int md, input bit up, input bit dn);
        int n;
        bit seen;
        wr(RVR_ADDR_VOLMIX, {1'b0, md[1:0], 5'h00});
        wr(RVR_ADDR_VOL_A, 8'($urandom));
        wr(RVR_ADDR_VOL_B, 8'($urandom));
        wr(RVR_ADDR_MODE3, {4'h0, up, dn, 2'h0});
        n = 0;
        while ((atten_a !== tgt(0) || atten_b !== tgt(1)) && n < 3000) begin
            tick();
            n++;
        end
        chk({1'b0, atten_a}, {1'b0, tgt(0)});
        if (kind == 0) reset_pin_n = 1'b0;
        else internal_reset_req = 1'b1;
        n = 0;
        do begin
            pa = atten_a;
            pb = atten_b;
            tick();
            n++;
            if (dn && md >= 2) chk({7'h0, (atten_a - pa) <= 1 && (atten_b - pb) <= 1}, 8'h01);
            if (reset_go === 1'b1) chk({1'b0, atten_a & atten_b}, 8'h7f);
        end while (dn && reset_go !== 1'b1 && n < 3000);
        if (!dn) chk({1'b0, atten_b}, 8'h7f);
        chk({7'h0, reset_go}, 8'h01);
        tick();
        reset_pin_n        = 1'b1;
        internal_reset_req = 1'b0;
        seen = 1'b0;
        n = 0;
        do begin
            pa = atten_a;
            pb = atten_b;
            tick();
            n++;
            if (ramp_busy === 1'b1) seen = 1'b1;
            if (up && md >= 2) chk({7'h0, (pa - atten_a) <= 1 && (pb - atten_b) <= 1}, 8'h01);
        end while (up && (ramp_busy !== 1'b0 || atten_a !== tgt(0)) && n < 3000);
        chk({1'b0, atten_a}, {1'b0, tgt(0)});
        chk({1'b0, atten_b}, {1'b0, tgt(1)});
        chk({7'h0, seen}, {7'h0, up});
    endtask : seq

    task automatic give_verdict;
        if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {rstn, ctl_wr, ctl_rd, internal_reset_req, sample_strobe} = 5'h00;
        {zero_cross_a, zero_cross_b} = 2'h0;
        reset_pin_n = 1'b1;
        ctl_addr    = 8'h00;
        ctl_wdata   = 8'h00;
        mismatches  = 0;
        num_checks  = 0;
        rg          = '{default: 8'h00};
        rg[2]       = RVR_VOLMIX_RST;
        void'($urandom(1170));
        repeat (3) @(posedge clk);
        #1;
        rstn = 1'b1;
        for (int a = 2; a < 8; a++) rd(8'(a));
        rd(8'h08 + 8'($urandom % 248));
        wr(RVR_ADDR_ID, 8'($urandom));
        rd(RVR_ADDR_ID);
        wr(RVR_ADDR_MODE3, 8'hff);
        rd(RVR_ADDR_MODE3);
        for (int m = 0; m < 4; m++)
            for (int k = 0; k < 2; k++)
                for (int u = 0; u < 2; u++)
                    for (int d = 0; d < 2; d++) seq(k, m, u[0], d[0]);
        give_verdict();
    end

    // Watchdog against hangs
    initial begin
        #500000;
        mismatches++;
        give_verdict();
    end
endmodule : tb
`default_nettype wire
